/* hw/twsh_core.sv */
/*
 * Master-transmitter engine of the two-wire interface with its software
 * handshake: completion flag, status code, shift register, START, byte
 * and STOP sequencing on open-drain SCL/SDA.
 * Assumes a pulled-up bus outside and a byte register port on clk.
 */
// Our own choices: the register offsets and strobed register access.
`default_nettype none
module twsh_core (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_we,
	input  wire logic       reg_re,
	output logic      [7:0] reg_rdata,
	input  wire logic       cpu_global_irq_en,
	output logic            irq,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_BYTE  = 3'b010,
		ST_ACK   = 3'b011,
		ST_STOP  = 3'b100
	} twsh_state_t;

	twsh_state_t state_q;
	logic [1:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic        flag_q;
	logic        ie_q;
	logic        en_q;
	logic        sta_q;
	logic        sto_q;
	logic [7:0]  code_q;
	logic [7:0]  status_q;
	logic [1:0]  ps_q;
	logic [7:0]  bitrate_q;
	logic [7:0]  data_q;
	logic [15:0] div_q;
	logic [15:0] div_lim;
	logic        tick;
	logic [1:0]  qtr_q;
	logic [2:0]  bit_q;
	logic        addr_phase_q;
	logic        nack_q;
	logic        ctl_wr;
	logic        go;
	logic        stall;
	logic        step;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        irq_q;
	logic [7:0]  rdata_q;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	twsh_sync #(.WIDTH(2)) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.async_i ({scl_i, sda_i}),
		.sync_o  (pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	assign ctl_wr = reg_we && (reg_addr == twsh_pkg::OFF_CONTROL);
	// a set flag bit written with enable is the only launch
	assign go = ctl_wr && reg_wdata[twsh_pkg::CTL_FLAG]
		&& reg_wdata[twsh_pkg::CTL_ENABLE] && (state_q == ST_IDLE);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ie_q  <= twsh_pkg::RST_CONTROL[twsh_pkg::CTL_IRQ_EN];
			en_q  <= twsh_pkg::RST_CONTROL[twsh_pkg::CTL_ENABLE];
			sta_q <= twsh_pkg::RST_CONTROL[twsh_pkg::CTL_START];
			sto_q <= twsh_pkg::RST_CONTROL[twsh_pkg::CTL_STOP];
		end else if (ctl_wr) begin
			ie_q  <= reg_wdata[twsh_pkg::CTL_IRQ_EN];
			en_q  <= reg_wdata[twsh_pkg::CTL_ENABLE];
			sta_q <= reg_wdata[twsh_pkg::CTL_START];
			sto_q <= reg_wdata[twsh_pkg::CTL_STOP];
		end else if (state_q == ST_STOP && step && qtr_q == 2'h3) begin
			sto_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bitrate_q <= twsh_pkg::RST_BITRATE;
			ps_q      <= twsh_pkg::RST_PS;
		end else if (reg_we && reg_addr == twsh_pkg::OFF_BITRATE) begin
			bitrate_q <= reg_wdata;
		end else if (reg_we && reg_addr == twsh_pkg::OFF_STATUS) begin
			ps_q <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// quarter-bit divider, stalled while a slave stretches SCL
	// ----------------------------------------------------------------
	assign div_lim = 16'(({8'h00, bitrate_q} + 16'h0001) << {ps_q, 1'b0});
	assign tick    = (div_q >= div_lim - 16'h0001);
	assign stall   = (qtr_q == 2'h2) && !scl_oe_q && !scl_s;
	assign step    = tick && !stall;

	always_ff @(posedge clk) begin
		if (!rst_n || state_q == ST_IDLE || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n || state_q == ST_IDLE) begin
			qtr_q <= 2'h0;
		end else if (step) begin
			qtr_q <= qtr_q + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			bit_q   <= 3'h7;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					bit_q <= 3'h7;
					if (go && reg_wdata[twsh_pkg::CTL_START]) begin
						state_q <= ST_START;
					end else if (go && reg_wdata[twsh_pkg::CTL_STOP]) begin
						state_q <= ST_STOP;
					end else if (go) begin
						state_q <= ST_BYTE;
					end
				end
				ST_START: if (step && qtr_q == 2'h3) begin
					state_q <= ST_IDLE;
				end
				ST_BYTE: if (step && qtr_q == 2'h3) begin
					bit_q <= bit_q - 3'h1;
					if (bit_q == 3'h0) begin
						state_q <= ST_ACK;
					end
				end
				ST_ACK, ST_STOP: if (step && qtr_q == 2'h3) begin
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// shift register, shared by address and data bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_q <= twsh_pkg::RST_DATA;
		end else if (state_q == ST_BYTE && step && qtr_q == 2'h2) begin
			data_q <= {data_q[6:0], sda_s};
		end else if (reg_we && reg_addr == twsh_pkg::OFF_DATA
			&& state_q == ST_IDLE) begin
			data_q <= reg_wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_phase_q <= 1'b0;
			nack_q       <= 1'b0;
		end else begin
			if (state_q == ST_START) begin
				addr_phase_q <= 1'b1;
			end else if (state_q == ST_ACK && step && qtr_q == 2'h3) begin
				addr_phase_q <= 1'b0;
			end
			if (state_q == ST_ACK && step && qtr_q == 2'h2) begin
				nack_q <= sda_s;
			end
		end
	end

	// ----------------------------------------------------------------
	// completion flag and status code
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
			code_q <= twsh_pkg::CODE_NO_INFO;
		end else if (state_q == ST_START && step && qtr_q == 2'h3) begin
			flag_q <= 1'b1;
			code_q <= twsh_pkg::CODE_START_SENT;
		end else if (state_q == ST_ACK && step && qtr_q == 2'h3) begin
			flag_q <= 1'b1;
			if (addr_phase_q) begin
				code_q <= nack_q ? twsh_pkg::CODE_ADDR_NACK
					: twsh_pkg::CODE_ADDR_ACK;
			end else begin
				code_q <= nack_q ? twsh_pkg::CODE_DATA_NACK
					: twsh_pkg::CODE_DATA_ACK;
			end
		end else if (ctl_wr && reg_wdata[twsh_pkg::CTL_FLAG]) begin
			flag_q <= 1'b0;
		end
	end
	// one cycle behind the flag; no-info whenever the flag is down
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_q <= twsh_pkg::CODE_NO_INFO;
		end else begin
			status_q <= flag_q ? code_q : twsh_pkg::CODE_NO_INFO;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers: enable high pulls the line low
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_oe_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			// a sent START or byte leaves SCL low while the flag waits
			scl_oe_q <= go ? scl_oe_q : flag_q;
		end else if (step) begin
			scl_oe_q <= (qtr_q == 2'h3 && state_q != ST_STOP) ||
				(qtr_q == 2'h0 && state_q != ST_START && state_q != ST_STOP);
		end
	end
	// data bits move sda only while scl is low, never on the edge that drops it; START and STOP move it with scl high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_oe_q <= 1'b0;
		end else if (go) begin
			if (!reg_wdata[twsh_pkg::CTL_START]) begin
				sda_oe_q <= reg_wdata[twsh_pkg::CTL_STOP] || !data_q[7];
			end
		end else if (step) begin
			unique case (state_q)
				ST_START: sda_oe_q <= (qtr_q != 2'h0);
				ST_BYTE:  if (qtr_q == 2'h0) begin
					sda_oe_q <= !data_q[7];
				end
				ST_ACK:   sda_oe_q <= 1'b0;
				ST_STOP:  sda_oe_q <= (qtr_q == 2'h0);
				default:  sda_oe_q <= sda_oe_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt and read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && ie_q && cpu_global_irq_en;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (reg_re) begin
			unique case (reg_addr)
				twsh_pkg::OFF_CONTROL: rdata_q <= {flag_q, 1'b0, sta_q, sto_q,
					1'b0, en_q, 1'b0, ie_q};
				// code in the top bits so a 0xf8 mask isolates it
				twsh_pkg::OFF_STATUS: rdata_q <= (status_q
					& twsh_pkg::STATUS_CODE_MASK)
					| ({6'h00, ps_q} & twsh_pkg::STATUS_PS_MASK);
				twsh_pkg::OFF_DATA:    rdata_q <= data_q;
				twsh_pkg::OFF_BITRATE: rdata_q <= bitrate_q;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;
	assign scl_oe    = scl_oe_q;
	assign sda_oe    = sda_oe_q;
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_FLAG_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
		flag_q |-> state_q == ST_IDLE)
		else $error("bus operation running with flag set");
	AST_SCL_HELD: assert property (@(posedge clk) disable iff (!rst_n)
		flag_q |-> scl_oe_q)
		else $error("scl released while flag set");
	AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_q && ctl_wr && reg_wdata[twsh_pkg::CTL_FLAG]) |=> !flag_q)
		else $error("flag not cleared by writing one");
	AST_NO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_q && ctl_wr && !reg_wdata[twsh_pkg::CTL_FLAG])
		|=> flag_q && state_q == ST_IDLE)
		else $error("write without flag bit acted");
	AST_START_GO: assert property (@(posedge clk) disable iff (!rst_n)
		(go && reg_wdata[twsh_pkg::CTL_START]) |=> state_q == ST_START)
		else $error("start request not launched");
	AST_START_CODE: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == ST_START && step && qtr_q == 2'h3)
		|=> flag_q ##1 status_q == twsh_pkg::CODE_START_SENT)
		else $error("start code missing");
	AST_STATUS_LAG: assert property (@(posedge clk) disable iff (!rst_n)
		!flag_q |=> status_q == twsh_pkg::CODE_NO_INFO)
		else $error("status not no-info without flag");
	AST_ACK_CODE: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == ST_ACK && step && qtr_q == 2'h3 && !addr_phase_q)
		|=> ##1 status_q == (nack_q ? twsh_pkg::CODE_DATA_NACK
		: twsh_pkg::CODE_DATA_ACK))
		else $error("data acknowledge code wrong");
	AST_STOP_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == ST_STOP && step && qtr_q == 2'h3)
		|=> !flag_q ##1 !scl_oe_q && !sda_oe_q)
		else $error("stop set flag or held bus");
	AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_q && ie_q && cpu_global_irq_en) ##1 !ctl_wr |-> irq_q)
		else $error("interrupt request missing");
endmodule
`default_nettype wire

/* hw/twsh_pkg.sv */
/*
 * Constants of the two-wire software handshake block: register offsets,
 * control field positions, reset values and status codes.
 * Assumes a byte-wide register port with a two-bit address.
 */
// Behaviour
// - set completion flag after each handled event
// - request interrupt only with both enables set
// - status holds event code while flag set
// - writing one to flag bit clears it
// - no new bus operation while flag set
// - clearing write launches operation it selects
// - after START set flag, START code
// - after address/data byte, code shows acknowledge
// - STOP completes without setting the flag
// - serial clock held low while flag set
// - code in upper bits, prescaler masked off
// - flag-clear, start and enable bits request START
// - one shift register for address and data
// - flag-clear with stop bit requests STOP; with the start bit also set the code sends only START
// - status updated cycle after flag, else no-info
// - successful START reads masked code 0x08
`default_nettype none
package twsh_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [1:0] OFF_CONTROL = 2'h0;
	localparam logic [1:0] OFF_STATUS  = 2'h1;
	localparam logic [1:0] OFF_DATA    = 2'h2;
	localparam logic [1:0] OFF_BITRATE = 2'h3;
	// ----------------------------------------------------------------
	// control field positions
	// ----------------------------------------------------------------
	localparam int CTL_FLAG   = 7;
	localparam int CTL_START  = 5;
	localparam int CTL_STOP   = 4;
	localparam int CTL_ENABLE = 2;
	localparam int CTL_IRQ_EN = 0;
	// ----------------------------------------------------------------
	// status layout and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_CODE_MASK = 8'hf8;
	localparam logic [7:0] STATUS_PS_MASK   = 8'h03;
	localparam logic [7:0] CODE_NO_INFO     = 8'hf8;
	localparam logic [7:0] CODE_START_SENT  = 8'h08;
	localparam logic [7:0] CODE_ADDR_ACK    = 8'h18;
	localparam logic [7:0] CODE_ADDR_NACK   = 8'h20;
	localparam logic [7:0] CODE_DATA_ACK    = 8'h28;
	localparam logic [7:0] CODE_DATA_NACK   = 8'h30;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_DATA    = 8'hff;
	localparam logic [7:0] RST_BITRATE = 8'h04;
	localparam logic [1:0] RST_PS      = 2'h0;
endpackage
`default_nettype wire

/* hw/twsh_sync.sv */
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to clk.
 */
`default_nettype none
module twsh_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_o <= '1;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* tb/twsh_slave_model.sv */
/*
 * Behavioural two-wire slave receiver facing the handshake engine.
 * Assumes pulled-up scl/sda wires resolved by the bench from all pulls.
 */
`default_nettype none
module twsh_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nack,
	input  wire logic       stretch,
	output logic            sda_pull,
	output logic            scl_pull,
	output logic      [7:0] rx_byte,
	output logic            stop_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	int   bits = 0;
	logic active = 1'b0;
	initial begin
		sda_pull = 1'b0;
		scl_pull = 1'b0;
		rx_byte = 8'h00;
		stop_seen = 1'b0;
	end
	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	always @(negedge sda) if (scl) begin
		active = 1'b1;
		bits = 0;
		stop_seen = 1'b0;
	end
	always @(posedge sda) if (scl && active) begin
		active = 1'b0;
		stop_seen = 1'b1;
	end
	// msb first, sampled while scl is high
	always @(posedge scl) if (active) begin
		if (bits < 8)
			rx_byte = {rx_byte[6:0], sda};
		bits = bits + 1;
	end
	always @(negedge scl) if (active) begin
		if (bits == 8)
			sda_pull = ~nack;
		else if (bits == 9) begin
			sda_pull = 1'b0;
			bits = 0;
		end
		// slow slave: holds the clock low for a while
		if (stretch) begin
			scl_pull = 1'b1;
			#300;
			scl_pull = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
 * Self-checking bench: register port master and slave model on the bus.
 * Assumes the core drives open-drain enables and a pulled-up bus.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		string      name;
		logic [7:0] exp;
		logic [7:0] mask;
	} twsh_note_t;
	logic       clk = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
	logic       gie = 1'b0, nack = 1'b0, stretch = 1'b0, re_seen = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_byte, rd_v, a;
	logic       irq, scl_oe, sda_oe, sda_pull, scl_pull, stop_seen;
	wire        scl = ~(scl_oe | scl_pull);
	wire        sda = ~(sda_oe | sda_pull);
	int         n_mismatch = 0, checked = 0, seed = 38799, cycles = 0;
	twsh_note_t notes[$];
	twsh_core i_twsh_core (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .cpu_global_irq_en(gie), .irq(irq),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
		.sda_oe(sda_oe));
	twsh_slave_model i_twsh_slave_model (.scl(scl), .sda(sda), .nack(nack),
		.stretch(stretch), .sda_pull(sda_pull), .scl_pull(scl_pull),
		.rx_byte(rx_byte), .stop_seen(stop_seen));
	always #5 clk = ~clk;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic results();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic compare(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// a zero mask notes a poll whose value only the driver uses
	task automatic rd(input logic [1:0] ad, input logic [7:0] e,
		input logic [7:0] m, input string nm);
		notes.push_back('{nm, e, m});
		@(posedge clk);
		reg_addr <= ad;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		rd_v = reg_rdata;
	endtask
	task automatic pins(input logic s_oe, input logic d_oe);
		@(negedge clk);
		compare("scl_oe", {7'h00, s_oe}, {7'h00, scl_oe});
		compare("sda_oe", {7'h00, d_oe}, {7'h00, sda_oe});
	endtask
	task automatic step(input logic [7:0] ctl, input logic [7:0] code,
		input logic irq_e);
		int i;
		wr(twsh_pkg::OFF_CONTROL, ctl);
		rd_v = 8'h00;
		for (i = 0; i < 400 && rd_v[7] !== 1'b1; i++)
			rd(twsh_pkg::OFF_CONTROL, 8'h00, 8'h00, "poll");
		compare("flag", 8'h80, rd_v & 8'h80);
		rd(twsh_pkg::OFF_STATUS, code, 8'hff, "status");
		repeat (30) @(posedge clk);
		@(negedge clk);
		compare("scl", 8'h00, {7'h00, scl});
		compare("irq", {7'h00, irq_e}, {7'h00, irq});
	endtask
	// ----------------------------------------------------------------
	// read result monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		twsh_note_t n;
		if (re_seen && notes.size() > 0) begin
			n = notes.pop_front();
			if (n.mask !== 8'h00)
				compare(n.name, n.exp & n.mask, reg_rdata & n.mask);
		end
		re_seen = reg_re;
	end
	// ceiling well above two transfers, the second with a stretching slave
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int t, k, w;
		logic [31:0] r;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(twsh_pkg::OFF_CONTROL, twsh_pkg::RST_CONTROL, 8'hff, "control");
		rd(twsh_pkg::OFF_STATUS, twsh_pkg::CODE_NO_INFO, 8'hff, "status");
		rd(twsh_pkg::OFF_DATA, twsh_pkg::RST_DATA, 8'hff, "data");
		rd(twsh_pkg::OFF_BITRATE, twsh_pkg::RST_BITRATE, 8'hff, "bitrate");
		// quarter of 3 cycles: 120 ns bit, nearest to the 125 ns link
		wr(twsh_pkg::OFF_BITRATE, 8'h02);
		wr(twsh_pkg::OFF_CONTROL, 8'h24);
		repeat (60) @(posedge clk);
		pins(1'b0, 1'b0);
		$display("test idle_write done");
		for (t = 0; t < 2; t++) begin
			@(posedge clk);
			stretch <= t[0];
			gie <= 1'b1;
			step(8'ha5, twsh_pkg::CODE_START_SENT, 1'b1);
			wr(twsh_pkg::OFF_CONTROL, 8'h25);
			repeat (60) @(posedge clk);
			pins(1'b1, 1'b1);
			rd(twsh_pkg::OFF_STATUS, twsh_pkg::CODE_START_SENT,
				twsh_pkg::STATUS_CODE_MASK, "status");
			r = $random(seed);
			a = {r[6:0], 1'b0};
			wr(twsh_pkg::OFF_DATA, a);
			nack <= t[0];
			gie <= 1'b0;
			step(8'h85, t[0] ? twsh_pkg::CODE_ADDR_NACK :
				twsh_pkg::CODE_ADDR_ACK, 1'b0);
			compare("rx_byte", a, rx_byte);
			rd(twsh_pkg::OFF_DATA, a, 8'hff, "data");
			for (k = 0; k < 2 * (1 - t); k++) begin
				r = $random(seed);
				wr(twsh_pkg::OFF_DATA, r[7:0]);
				nack <= k[0];
				gie <= 1'b1;
				step(8'h85 - {7'h00, k[0]}, k[0] ? twsh_pkg::CODE_DATA_NACK :
					twsh_pkg::CODE_DATA_ACK, ~k[0]);
				compare("rx_byte", r[7:0], rx_byte);
			end
			wr(twsh_pkg::OFF_CONTROL, 8'h94);
			for (w = 0; w < 500 && stop_seen !== 1'b1; w++)
				@(posedge clk);
			compare("stop", 8'h01, {7'h00, stop_seen});
			repeat (40) @(posedge clk);
			rd(twsh_pkg::OFF_CONTROL, 8'h00, 8'h80, "flag");
			rd(twsh_pkg::OFF_STATUS, twsh_pkg::CODE_NO_INFO, 8'hff,
				"status");
			pins(1'b0, 1'b0);
			$display("test transfer %0d done", t);
		end
		results();
	end
endmodule
`default_nettype wire
